// ### design/sfd_decoder.sv
/*
  Direct register address decoder: area select, system and port page
  registers, and one-hot routing of each access outside these local registers to its target.
  Assumes the core presents address, read and write strobes in one cycle
  and that peripherals return read data in that same cycle.
*/
// Overview of operation
// R1 - bit 0 of system control selects standard (0) or mapped (1) area
// R2 - system control bit 2 reads as one always
// R3 - system control bits 7..5, 3, 1 read as zero always
// R4 - software changes area select only by read-modify-write AND or OR
// R5 - paged peripherals take their page from their own page register
// R6 - software sets page and area select before paged accesses
// R7 - each module has its own page count and page size
// R8 - system control at 8F, decoded in both areas, resets to 04
// R9 - other system registers only in standard area, paged by BF
// R10 - watchdog registers decode only in mapped area
// R11 - port registers only in standard area, paged by B2
// R12 - debug registers decode only in mapped area
// R13 - register space is direct addresses 80 to FF
// R14 - hardware never clears area select by itself
// R15 - each access routes to exactly one target in the same cycle
`timescale 1ns/1ps
module sfd_decoder (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_periph_rdata,
  input wire logic i_wdt_hit,
  input wire logic i_dbg_hit,
  input wire logic i_other_hit,
  output logic [7:0] o_rdata,
  output logic o_area_select,
  output logic o_imode,
  output logic [2:0] o_sys_page,
  output logic [2:0] o_port_page,
  output logic o_sel_sysctl,
  output logic o_sel_watchdog,
  output logic o_sel_port,
  output logic o_sel_debug,
  output logic o_sel_other,
  output logic o_sel_none,
  output logic o_periph_rd,
  output logic o_periph_wr
);
  logic area_r;
  logic imode_r;
  logic in_space;
  logic hit_sc0;
  logic hit_syspg;
  logic hit_portpg;
  logic local_hit;
  logic [7:0] sc0_value;
  logic in_sys_range;
  logic [7:0] rd_mux;
  sfd_pkg::sfd_target_type target;
  sfd_page_if sys_pg ();
  sfd_page_if port_pg ();

  function automatic logic is_at(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  assign in_space = i_addr >= sfd_pkg::SFR_LO; // see R13
  assign hit_sc0 = is_at(i_addr, sfd_pkg::SYSTEM_CONTROL_0_ADDR); // see R8
  assign hit_syspg = !area_r && is_at(i_addr, sfd_pkg::SYS_PAGE_ADDR); // see R9
  assign hit_portpg = !area_r && is_at(i_addr, sfd_pkg::PORT_PAGE_ADDR); // see R11
  assign local_hit = hit_sc0 || hit_syspg || hit_portpg;

  // see R2, R3: constant bits are forced, never stored
  assign sc0_value = {3'h0, imode_r, 1'b0, 1'b1, 1'b0, area_r};

  assign in_sys_range = i_addr >= sfd_pkg::SYS_RANGE_LO && i_addr <= sfd_pkg::SYS_RANGE_HI;

  // priority gives one target only; watchdog wins an overlap at BB..BF mapped (see R15)
  assign target = !in_space ? sfd_pkg::TGT_NONE :
                  local_hit ? sfd_pkg::TGT_LOCAL :
                  (area_r && i_wdt_hit) ? sfd_pkg::TGT_WATCHDOG : // see R10
                  (area_r && i_dbg_hit) ? sfd_pkg::TGT_DEBUG : // see R12
                  area_r ? sfd_pkg::TGT_NONE :
                  i_other_hit ? sfd_pkg::TGT_OTHER :
                  in_sys_range ? sfd_pkg::TGT_SYSCTL : // see R9
                  sfd_pkg::TGT_PORT; // see R11

  assign o_sel_sysctl = target == sfd_pkg::TGT_SYSCTL;
  assign o_sel_watchdog = target == sfd_pkg::TGT_WATCHDOG;
  assign o_sel_port = target == sfd_pkg::TGT_PORT;
  assign o_sel_debug = target == sfd_pkg::TGT_DEBUG;
  assign o_sel_other = target == sfd_pkg::TGT_OTHER;
  assign o_sel_none = target == sfd_pkg::TGT_NONE;
  assign o_periph_rd = i_rd && !local_hit && in_space;
  assign o_periph_wr = i_wr && !local_hit && in_space;

  // pages come from each module's own register (see R5)
  assign sys_pg.wr = i_wr && hit_syspg;
  assign sys_pg.wdata = i_wdata;
  assign port_pg.wr = i_wr && hit_portpg;
  assign port_pg.wdata = i_wdata;
  assign o_sys_page = sys_pg.page;
  assign o_port_page = port_pg.page;
  assign o_area_select = area_r;
  assign o_imode = imode_r;

  sfd_page_reg #(.NUM_PAGES(sfd_pkg::SYS_PAGES)) u_sys_page (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .pg(sys_pg)
  ); // see R7
  sfd_page_reg #(.NUM_PAGES(sfd_pkg::PORT_PAGES)) u_port_page (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .pg(port_pg)
  );

  assign rd_mux = hit_sc0 ? sc0_value : hit_syspg ? sys_pg.rdata :
                  hit_portpg ? port_pg.rdata :
                  (target != sfd_pkg::TGT_NONE) ? i_periph_rdata : 8'h00;

  // read data registered at the edge that takes the read strobe, held until the next read
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end
  end

  // only a write to 8F changes area select (see R1, R14)
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      area_r <= sfd_pkg::SYSTEM_CONTROL_0_RESET[sfd_pkg::AREA_BIT]; // see R8
      imode_r <= sfd_pkg::SYSTEM_CONTROL_0_RESET[sfd_pkg::IMODE_BIT];
    end else if (i_wr && hit_sc0) begin
      area_r <= i_wdata[sfd_pkg::AREA_BIT];
      imode_r <= i_wdata[sfd_pkg::IMODE_BIT];
    end
  end
endmodule

// ### design/sfd_page_reg.sv
/*
  Module page register with page field, store slot and store/restore
  operation. Small slot memory holds saved pages.
  Assumes writes come as single-cycle strobes on the system clock.
*/
`timescale 1ns/1ps
module sfd_page_reg #(
  parameter logic [2:0] NUM_PAGES = 3'h4
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  sfd_page_if.reg_side pg
);
  logic [2:0] page_r;
  logic [2:0] store_r [sfd_pkg::N_SLOTS];
  logic [1:0] op;
  logic [1:0] slot;
  logic [2:0] wpage;
  logic [2:0] page_nxt;

  assign op = pg.wdata[sfd_pkg::OP_LSB +: 2];
  assign slot = pg.wdata[sfd_pkg::SLOT_LSB +: 2];
  // pages beyond this module's count are clipped to its last page (see R7)
  assign wpage = (pg.wdata[2:0] >= NUM_PAGES) ? NUM_PAGES - 3'h1 : pg.wdata[2:0];
  assign page_nxt = (op == sfd_pkg::OP_RESTORE) ? store_r[slot] : wpage;
  assign pg.page = page_r;
  assign pg.rdata = {4'h0, 1'b0, page_r};

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      page_r <= sfd_pkg::PAGE_REG_RESET[2:0];
    end else if (pg.wr) begin
      page_r <= page_nxt;
    end
  end

  // saved pages hold no control meaning, so no reset is needed
  always_ff @(posedge i_mclk) begin
    if (pg.wr && op == sfd_pkg::OP_STORE) begin
      store_r[slot] <= page_r;
    end
  end
endmodule

// ### pkg/sfd_page_if.sv
/*
  Interface carrying a page register's write request and selected page
  between the decoder top and its page register modules.
  Assumes the top drives writes and reads back the current value.
*/
`timescale 1ns/1ps
interface sfd_page_if;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0] page;
  modport ctl (output wr, output wdata, input rdata, input page);
  modport reg_side (input wr, input wdata, output rdata, output page);
endinterface

// ### pkg/sfd_pkg.sv
/*
  Package for the register address decoder: register offsets, reset values,
  field positions, page geometry and the target enumeration.
  Assumes a single system clock and an 8-bit direct register address.
*/
package sfd_pkg;
  localparam logic [7:0] SFR_LO = 8'h80;
  localparam logic [7:0] SYSTEM_CONTROL_0_ADDR = 8'h8f;
  localparam logic [7:0] PORT_PAGE_ADDR = 8'hb2;
  localparam logic [7:0] SYS_PAGE_ADDR = 8'hbf;
  // standard-area system register window below the system page register
  localparam logic [7:0] SYS_RANGE_LO = 8'hb3;
  localparam logic [7:0] SYS_RANGE_HI = 8'hbe;
  localparam logic [7:0] SYSTEM_CONTROL_0_RESET = 8'h04;
  localparam logic [7:0] PAGE_REG_RESET = 8'h00;
  localparam int AREA_BIT = 0;
  localparam int IMODE_BIT = 4;
  localparam int ONE_BIT = 2;
  localparam int PAGE_W = 3;
  localparam int SLOT_LSB = 4;
  localparam int OP_LSB = 6;
  localparam int N_SLOTS = 4;
  // page geometry is set per module; both modules have 4 pages
  localparam logic [2:0] SYS_PAGES = 3'h4;
  localparam logic [2:0] PORT_PAGES = 3'h4;
  // page_operation codes
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_NONE2 = 2'h1;
  localparam logic [1:0] OP_STORE = 2'h2;
  localparam logic [1:0] OP_RESTORE = 2'h3;
  typedef enum logic [2:0] {
    TGT_NONE, TGT_LOCAL, TGT_SYSCTL, TGT_WATCHDOG, TGT_PORT, TGT_DEBUG, TGT_OTHER
  } sfd_target_type;
endpackage

// ### test/sfd_checker.sv
/* assertions on the decoder ports: area select, fixed bits, routing, pages.
   assumes one clock domain and a bind onto sfd_decoder. */
`timescale 1ns/1ps
module sfd_checker (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_area_select,
  input wire logic [2:0] o_sys_page,
  input wire logic [2:0] o_port_page,
  input wire logic o_sel_watchdog,
  input wire logic o_sel_port,
  input wire logic o_sel_debug,
  input wire logic o_sel_none,
  input wire logic o_periph_wr
);
  // a page beyond the count is clipped to the last one
  wire logic [2:0] pg_want = (i_wdata[2:0] >= sfd_pkg::PORT_PAGES) ?
    sfd_pkg::PORT_PAGES - 3'h1 : i_wdata[2:0];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_ctl_wr;
    i_wr && i_addr == 8'h8f;
  endsequence
  a_area_follows_wr: assert property (s_ctl_wr |=> o_area_select == $past(i_wdata[0]))
    else $error("area select missed its write");
  a_area_holds: assert property (!(i_wr && i_addr == 8'h8f) |=> $stable(o_area_select))
    else $error("area select changed without write");
  a_ctl_fixed_bits: assert property (i_rd && i_addr == 8'h8f
    |=> (o_rdata & 8'hee) == 8'h04) else $error("fixed control bits wrong");
  a_local_no_strobe: assert property (i_addr == 8'h8f |-> !o_periph_wr)
    else $error("control register write reached peripherals");
  a_wdog_mapped: assert property (o_sel_watchdog |-> o_area_select)
    else $error("watchdog selected in standard area");
  a_debug_mapped: assert property (o_sel_debug |-> o_area_select)
    else $error("debug selected in standard area");
  a_port_standard: assert property (o_sel_port |-> !o_area_select)
    else $error("port selected in mapped area");
  a_low_addr_none: assert property (!i_addr[7] |-> o_sel_none && !o_periph_wr)
    else $error("low address routed");
  a_port_page_wr: assert property (i_wr && i_addr == 8'hb2 && !o_area_select
    && !i_wdata[7] |=> o_port_page == $past(pg_want)) else $error("port page not loaded");
  a_sys_page_keep: assert property (i_wr && i_addr == 8'hbf && o_area_select
    |=> $stable(o_sys_page)) else $error("system page written in mapped area");
endmodule
bind sfd_decoder sfd_checker u_chk (.i_mclk, .i_rst_n, .i_addr, .i_rd, .i_wr, .i_wdata,
  .o_rdata, .o_area_select, .o_sys_page, .o_port_page, .o_sel_watchdog, .o_sel_port,
  .o_sel_debug, .o_sel_none, .o_periph_wr);

// ### test/sfd_core_model.sv
/* core model: one direct access per access call, a read then a write per rmw call, plus peripheral read data.
   assumes calls start between edges; strobes last one cycle. */
`timescale 1ns/1ps
module sfd_core_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic [7:0] o_periph_rdata
);
  initial o_addr = 8'h00;
  initial o_rd = 1'b0;
  initial o_wr = 1'b0;
  initial o_wdata = 8'h00;
  // inverted address so a stale or floating value never matches
  assign o_periph_rdata = ~o_addr;
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_wr = w;
    o_rd = !w;
    o_wdata = d;
    @(negedge i_mclk);
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  // read-modify-write keeps the other control bits as read
  task automatic rmw(input logic v);
    access(1'b0, 8'h8f, 8'h00);
    access(1'b1, 8'h8f, v ? (i_rdata | 8'h01) : (i_rdata & 8'hfe));
  endtask
endmodule

// ### test/tb.sv
/* testbench for sfd_decoder: control register, routing and page registers.
   assumes the core model drives the bus and the bench drives the hit lines. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic wh = 1'b0, dh = 1'b0, oh = 1'b0;
  logic [7:0] addr, wdata, prd, rdata;
  logic rd, wr, area, imode, s_sys, s_wd, s_port, s_dbg, s_oth, s_none;
  logic [2:0] sys_pg, port_pg;
  logic p_rd, p_wr, p_rd_q, p_wr_q;
  int fails = 0, checked = 0;
  always #25 i_mclk = ~i_mclk;
  sfd_core_model core (.i_mclk, .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr),
    .o_wdata(wdata), .o_periph_rdata(prd));
  sfd_decoder DUT (.i_mclk, .i_rst_n, .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata),
    .i_periph_rdata(prd), .i_wdt_hit(wh), .i_dbg_hit(dh), .i_other_hit(oh), .o_rdata(rdata),
    .o_area_select(area), .o_imode(imode), .o_sys_page(sys_pg), .o_port_page(port_pg),
    .o_sel_sysctl(s_sys), .o_sel_watchdog(s_wd), .o_sel_port(s_port), .o_sel_debug(s_dbg),
    .o_sel_other(s_oth), .o_sel_none(s_none), .o_periph_rd(p_rd), .o_periph_wr(p_wr));
  // strobes last only during the access, so keep what the taking edge saw
  always @(posedge i_mclk) begin
    p_rd_q <= p_rd;
    p_wr_q <= p_wr;
  end
  task automatic t_area();
    core.access(1'b0, 8'h8f, 8'h00);
    `CHK("ctl", 8'h04, rdata)
    core.rmw(1'b1);
    `CHK("area", 1'b1, area)
    `CHK("periph wr", 1'b0, p_wr_q)
    core.access(1'b1, 8'h8f, 8'hff);
    core.access(1'b0, 8'h8f, 8'h00);
    `CHK("ctl", 8'h15, rdata)
    core.access(1'b1, 8'h80, 8'h00);
    `CHK("area", 1'b1, area)
    `CHK("periph wr", 1'b1, p_wr_q)
    core.rmw(1'b0);
    `CHK("imode", 1'b1, imode)
    $display("t_area done");
  endtask
  task automatic t_route();
    core.access(1'b0, 8'h80, 8'h00);
    `CHK("port", 1'b1, s_port)
    `CHK("periph rd", 1'b1, p_rd_q)
    `CHK("rdata", 8'h7f, rdata)
    oh = 1'b1;
    core.access(1'b0, 8'h80, 8'h00);
    `CHK("other", 1'b1, s_oth)
    oh = 1'b0;
    core.access(1'b0, 8'hb4, 8'h00);
    `CHK("sysctl", 1'b1, s_sys)
    core.access(1'b0, 8'h7f, 8'h00);
    `CHK("none", 1'b1, s_none)
    `CHK("periph rd", 1'b0, p_rd_q)
    `CHK("rdata", 8'h00, rdata)
    core.rmw(1'b1);
    wh = 1'b1;
    core.access(1'b0, 8'hbc, 8'h00);
    `CHK("wdog", 1'b1, s_wd)
    wh = 1'b0;
    dh = 1'b1;
    core.access(1'b0, 8'hf1, 8'h00);
    `CHK("debug", 1'b1, s_dbg)
    dh = 1'b0;
    core.rmw(1'b0);
    $display("t_route done");
  endtask
  task automatic t_pages();
    core.access(1'b1, 8'hb2, 8'h02);
    core.access(1'b0, 8'hb2, 8'h00);
    `CHK("port page", 8'h02, rdata)
    core.access(1'b1, 8'hb2, 8'h07);
    `CHK("port page", 3'h3, port_pg)
    `CHK("periph wr", 1'b0, p_wr_q)
    core.access(1'b1, 8'hb2, 8'h91);
    `CHK("port page", 3'h1, port_pg)
    core.access(1'b1, 8'hb2, 8'hd0);
    `CHK("port page", 3'h3, port_pg)
    core.access(1'b1, 8'hbf, 8'h02);
    core.rmw(1'b1);
    core.access(1'b1, 8'hbf, 8'h01);
    `CHK("sys page", 3'h2, sys_pg)
    `CHK("periph wr", 1'b1, p_wr_q)
    core.rmw(1'b0);
    $display("t_pages done");
  endtask
  // a reset in mid-run must bring back the documented values
  task automatic t_reset();
    core.access(1'b1, 8'hb2, 8'h01);
    core.rmw(1'b1);
    @(negedge i_mclk);
    i_rst_n = 1'b0;
    @(negedge i_mclk);
    i_rst_n = 1'b1;
    `CHK("area", 1'b0, area)
    `CHK("port page", 3'h0, port_pg)
    `CHK("rdata", 8'h00, rdata)
    core.access(1'b0, 8'h8f, 8'h00);
    `CHK("ctl", 8'h04, rdata)
    `CHK("imode", 1'b0, imode)
    $display("t_reset done");
  endtask
  task automatic complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge i_mclk);
    i_rst_n = 1'b1;
    t_area();
    t_route();
    t_pages();
    t_reset();
    complete_run();
  end
  // the tests need well under 200 cycles
  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule
